// >>> hw/os_filter_pkg.sv
// Purpose: constants for the oversampling average filter
// Assumes: core_clk at 125 MHz, synchronous active-high reset
// Notes: sample timing and rates expressed as cycle counts
package os_filter_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CHANNELS = 8;
	localparam int SAMPLE_WIDTH = 18;
	localparam int MAX_LOG_DEPTH = 6;
	localparam int SUM_WIDTH = SAMPLE_WIDTH + MAX_LOG_DEPTH;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int BASE_RATE_KSPS = 200;
	// cycles per single conversion at the unaveraged rate
	localparam int CONV_CYCLES = CLK_FREQ_KHZ / BASE_RATE_KSPS;
	localparam int CONV_CNT_WIDTH = 10;
	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [2:0] RATIO_NONE = 3'h0;
	localparam logic [2:0] RATIO_INVALID = 3'h7;
	localparam logic [MAX_LOG_DEPTH:0] DEPTH_ONE = 7'h01;
	typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_DONE} filt_state_e;
endpackage : os_filter_pkg

// >>> hw/oversampling_average_filter.sv
// Purpose: averaging filter and reference source control of the converter
// Assumes: conversions arrive on sample_data with sample_valid per sample
// Notes: host keeps ratio steady during a set; code 111 acts as no averaging
`timescale 1ns/1ps
module oversampling_average_filter
	import os_filter_pkg::*;
(
	input wire logic core_clk, // conversion clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [2:0] oversample_ratio_sel, // averaging depth code
	input wire logic conv_start_group_a, // start, ANDed with group b; rise begins a set of all 8 channels
	input wire logic conv_start_group_b, // start, ANDed with group a; rise begins a set of all 8 channels
	input wire logic reference_source_sel, // high selects internal reference
	input wire logic reference_io_pin_in, // level seen on reference pin
	input wire logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] sample_data, // raw conversions
	input wire logic sample_valid, // pulse: sample_data holds a conversion
	output logic sample_trigger, // pulse: start one conversion
	output logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] result_data, // averaged words
	output logic result_valid, // pulse: result_data updated
	output logic busy, // averaging set in progress
	output logic reference_io_pin_out, // internal reference driven
	output logic reference_io_pin_oe, // pin driven by device
	output logic bandgap_enable, // internal band-gap powered
	output logic ref_gain_amp_enable // reference gain amplifier on
);
	// ----------------------------------------------------------------
	// reference source, purely combinational
	// ----------------------------------------------------------------
	assign bandgap_enable = reference_source_sel;
	assign reference_io_pin_oe = reference_source_sel;
	assign reference_io_pin_out = reference_source_sel;
	// released pin is a plain input; level is only observed
	wire ext_ref_seen = ~reference_source_sel & reference_io_pin_in;
	assign ref_gain_amp_enable = 1'b1;

	// ----------------------------------------------------------------
	// ratio decode
	// ----------------------------------------------------------------
	// log2 of depth; invalid code treated as no averaging
	function automatic logic [2:0] log_depth(input logic [2:0] code);
		if (code == RATIO_INVALID) begin
			return 3'h0;
		end
		return code;
	endfunction : log_depth

	wire [2:0] shift_amt = log_depth(oversample_ratio_sel);

	// ----------------------------------------------------------------
	// start edge detect
	// ----------------------------------------------------------------
	logic start_d; // previous start level
	wire start_level = conv_start_group_a & conv_start_group_b;
	wire start_rise = start_level & ~start_d;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			start_d <= 1'b0;
		end else begin
			start_d <= start_level;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	filt_state_e state; // current state
	filt_state_e next_state; // next state
	logic [MAX_LOG_DEPTH:0] taken; // samples collected this set
	logic [CONV_CNT_WIDTH-1:0] pace; // cycles since last trigger
	logic [2:0] set_shift; // depth latched at set start
	wire last_sample = sample_valid && (taken + 7'h01 == (DEPTH_ONE << set_shift));
	wire pace_done = pace >= CONV_CNT_WIDTH'(CONV_CYCLES - 1);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_rise) begin
					next_state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (last_sample) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// internal trigger once pacing elapsed and previous sample returned
	logic waiting; // a trigger awaits its sample
	assign sample_trigger = (state == ST_IDLE && start_rise)
		|| (state == ST_CONVERT && !waiting && pace_done);
	assign busy = (state != ST_IDLE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			waiting <= 1'b0;
			pace <= '0;
			taken <= '0;
			set_shift <= 3'h0;
		end else begin
			state <= next_state;
			// pacing counter restarts on every trigger
			pace <= sample_trigger ? '0 : (pace_done ? pace : pace + 1'b1);
			if (sample_trigger) begin
				waiting <= 1'b1;
			end else if (sample_valid) begin
				waiting <= 1'b0;
			end
			if (state == ST_IDLE) begin
				taken <= '0;
				set_shift <= shift_amt;
			end else if (sample_valid) begin
				taken <= taken + 7'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel accumulators
	// ----------------------------------------------------------------
	logic result_strobe; // result register update
	assign result_strobe = (state == ST_CONVERT) && last_sample;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			logic signed [SUM_WIDTH-1:0] acc; // running sum
			wire signed [SAMPLE_WIDTH-1:0] smp = sample_data[ch*SAMPLE_WIDTH +: SAMPLE_WIDTH];
			wire signed [SUM_WIDTH-1:0] sum = acc + SUM_WIDTH'(smp);
			wire signed [SUM_WIDTH-1:0] avg = sum >>> set_shift;

			always_ff @(posedge core_clk) begin
				if (rst || state == ST_IDLE) begin
					acc <= '0;
				end else if (sample_valid && state == ST_CONVERT) begin
					acc <= sum;
				end
			end

			// decimated word, two's complement low bits
			always_ff @(posedge core_clk) begin
				if (rst) begin
					result_data[ch*SAMPLE_WIDTH +: SAMPLE_WIDTH] <= '0;
				end else if (result_strobe) begin
					result_data[ch*SAMPLE_WIDTH +: SAMPLE_WIDTH] <= avg[SAMPLE_WIDTH-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_valid <= 1'b0;
		end else begin
			result_valid <= result_strobe;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [MAX_LOG_DEPTH:0] trig_count; // triggers in current set
	always_ff @(posedge core_clk) begin
		if (rst || state == ST_IDLE) begin
			trig_count <= sample_trigger ? 7'h01 : 7'h00;
		end else if (sample_trigger) begin
			trig_count <= trig_count + 7'h01;
		end
	end

	// saturating cycle count since the last trigger, kept apart from the pacer
	logic [CONV_CNT_WIDTH-1:0] since_trig; // cycles since last trigger
	always_ff @(posedge core_clk) begin
		if (rst || sample_trigger) begin
			since_trig <= '0;
		end else if (since_trig != '1) begin
			since_trig <= since_trig + 1'b1;
		end
	end

	AST_REF_FOLLOWS: assert property (@(posedge core_clk)
		reference_io_pin_oe == reference_source_sel && bandgap_enable == reference_source_sel)
		else $error("reference pin drive does not follow select");
	AST_AMP_ON: assert property (@(posedge core_clk) ref_gain_amp_enable)
		else $error("reference amplifier disabled");
	AST_FIRST_ON_EDGE: assert property (@(posedge core_clk) disable iff (rst)
		(state == ST_IDLE && start_rise) |-> sample_trigger ##1 state == ST_CONVERT)
		else $error("first sample not taken on start edge");
	AST_NO_TRIG_IDLE: assert property (@(posedge core_clk) disable iff (rst)
		(state == ST_IDLE && !start_rise) |-> !sample_trigger)
		else $error("trigger without start while idle");
	AST_TRIG_LIMIT: assert property (@(posedge core_clk) disable iff (rst)
		trig_count <= (DEPTH_ONE << set_shift) || state == ST_IDLE)
		else $error("more triggers than averaging depth");
	AST_PACING: assert property (@(posedge core_clk) disable iff (rst)
		(state == ST_CONVERT && sample_trigger) |=> !sample_trigger [*8])
		else $error("internal triggers too close");
	AST_RESULT_PULSE: assert property (@(posedge core_clk) disable iff (rst)
		result_strobe |=> result_valid ##1 !result_valid)
		else $error("result valid not a single pulse after set end");
	AST_NO_AVG: assert property (@(posedge core_clk) disable iff (rst)
		(result_strobe && set_shift == 3'h0) |=>
		result_data[SAMPLE_WIDTH-1:0] == $past(sample_data[SAMPLE_WIDTH-1:0]))
		else $error("unaveraged result differs from sample");
	AST_PACE_FULL: assert property (@(posedge core_clk) disable iff (rst)
		(state == ST_CONVERT && sample_trigger) |-> since_trig >= CONV_CNT_WIDTH'(CONV_CYCLES - 1))
		else $error("internal trigger before a full conversion time");
	AST_IDLE_AFTER_SET: assert property (@(posedge core_clk) disable iff (rst)
		result_valid |=> !busy)
		else $error("set did not return to idle after its result");

	// ----------------------------------------------------------------
	// coverage of the main scenarios
	// ----------------------------------------------------------------
	COV_DEPTH64: cover property (@(posedge core_clk) result_strobe && set_shift == 3'h6);
	COV_NO_OS: cover property (@(posedge core_clk) result_strobe && set_shift == 3'h0);
	COV_EXT_REF: cover property (@(posedge core_clk) ext_ref_seen);
	COV_IGNORED_START: cover property (@(posedge core_clk) state == ST_CONVERT && start_rise);
endmodule : oversampling_average_filter

// >>> verif/conv_source_model.sv
// Purpose: conversion source answering each sample trigger
// Assumes: dly below the 625-cycle pacing
// Notes: data lines toggle while no sample is offered
`timescale 1ns/1ps
module conv_source_model
	import os_filter_pkg::*;
(
	input wire logic core_clk,
	input wire logic sample_trigger,
	input wire logic busy,
	input wire logic [7:0] dly,
	output logic [143:0] sample_data,
	output logic sample_valid
);
	int k = 0; // sample index within a set
	int wait_cnt = -1; // cycles until the answer
	// sample value of set index k, channel n
	function automatic logic [17:0] val(input int k, input int n);
		return 18'(n * 1000 - k * 37 - 4000);
	endfunction : val
	initial sample_data = '0;
	initial sample_valid = 1'b0;
	// one answer per trigger, dly+1 cycles after the trigger edge
	always @(posedge core_clk) begin
		sample_valid <= 1'b0;
		sample_data <= ~sample_data;
		if (sample_trigger) begin
			if (!busy) k = 0;
			wait_cnt = dly;
		end else if (wait_cnt > 0) begin
			wait_cnt = wait_cnt - 1;
		end else if (wait_cnt == 0) begin
			for (int n = 0; n < 8; n++) sample_data[n*18+:18] <= val(k, n);
			sample_valid <= 1'b1;
			k = k + 1;
			wait_cnt = -1;
		end
	end
endmodule : conv_source_model

// >>> verif/tb_oversampling_average_filter.sv
// Purpose: self-checking bench of the averaging filter
// Assumes: 125 MHz clock, inputs driven at the falling edge
// Notes: covers every depth code, reference modes
`timescale 1ns/1ps
module tb_oversampling_average_filter;
	import os_filter_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] sel = 3'h0;
	logic start = 1'b0; // one line feeds both starts
	logic ref_sel = 1'b1;
	logic [7:0] dly = 8'h00;
	logic trig, rv, busy, pin_out, pin_oe, bg_en, amp_en, sv, pin_in;
	logic [143:0] sdata, rdata;
	int mismatches = 0;
	int check_count = 0;
	always #4 core_clk = ~core_clk;
	// outside reference present while the pin is released
	assign pin_in = pin_oe ? pin_out : 1'b1;
	oversampling_average_filter oversampling_average_filter_inst (.core_clk(core_clk),
		.rst(rst), .oversample_ratio_sel(sel), .reference_source_sel(ref_sel),
		.conv_start_group_a(start), .conv_start_group_b(start),
		.reference_io_pin_in(pin_in), .sample_data(sdata), .sample_valid(sv),
		.sample_trigger(trig), .result_data(rdata), .result_valid(rv), .busy(busy),
		.reference_io_pin_out(pin_out), .reference_io_pin_oe(pin_oe),
		.bandgap_enable(bg_en), .ref_gain_amp_enable(amp_en));
	conv_source_model host (.core_clk(core_clk), .sample_trigger(trig), .busy(busy),
		.dly(dly), .sample_data(sdata), .sample_valid(sv));
	task automatic chk_word(input logic [143:0] got, input logic [143:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk_bit
	task automatic conclude();
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	// one averaging set; for depth above 1, with an ignored start edge while busy
	task automatic run_set(input logic [2:0] code, input int depth, input int sh,
		input logic [7:0] d);
		int nt;
		int gap;
		int cyc;
		logic [143:0] exp;
		logic signed [23:0] s;
		nt = 0;
		gap = 0;
		cyc = 0;
		@(negedge core_clk);
		sel = code;
		dly = d;
		start = 1'b1;
		while (rv !== 1'b1 && cyc < 50000) begin
			#1;
			if (trig === 1'b1) begin
				if (nt > 0) chk_bit(gap >= CONV_CYCLES, 1'b1, "trigger spacing");
				nt++;
				gap = 0;
			end
			@(negedge core_clk);
			gap++;
			cyc++;
			if (cyc == 3) start = 1'b0;
			if (cyc == 5 && depth > 1) start = 1'b1;
		end
		for (int n = 0; n < 8; n++) begin
			s = '0;
			for (int k = 0; k < depth; k++) s = s + $signed(host.val(k, n));
			exp[n*18+:18] = 18'(s >>> sh);
		end
		chk_bit(rv, 1'b1, "result valid seen");
		chk_word(rdata, exp, "averaged words");
		chk_bit(nt == depth, 1'b1, "trigger count");
		@(negedge core_clk);
		@(negedge core_clk);
		chk_bit(busy, 1'b0, "busy after set");
		start = 1'b0;
	endtask : run_set
	// reference mode follows the select with no clock edge
	task automatic ref_check();
		@(negedge core_clk);
		ref_sel = 1'b0;
		#1;
		chk_bit(pin_oe, 1'b0, "pin released");
		chk_bit(bg_en, 1'b0, "band-gap off");
		chk_bit(amp_en, 1'b1, "amp on, external");
		ref_sel = 1'b1;
		#1;
		chk_bit(pin_oe, 1'b1, "pin driven");
		chk_bit(pin_out, 1'b1, "internal level");
		chk_bit(amp_en, 1'b1, "amp on, internal");
	endtask : ref_check
	// reset in the middle of a set returns to idle with results cleared
	task automatic reset_mid_set();
		@(negedge core_clk);
		sel = 3'h2;
		dly = 8'h00;
		start = 1'b1;
		repeat (10) @(negedge core_clk);
		chk_bit(busy, 1'b1, "busy during set");
		rst = 1'b1;
		@(negedge core_clk);
		chk_bit(busy, 1'b0, "busy after mid-set reset");
		chk_bit(rv, 1'b0, "valid after mid-set reset");
		chk_word(rdata, '0, "result after mid-set reset");
		start = 1'b0;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
	endtask : reset_mid_set
	initial begin
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		chk_word(rdata, '0, "result after reset");
		chk_bit(rv, 1'b0, "valid after reset");
		ref_check();
		for (int c = 0; c < 7; c++) run_set(3'(c), 1 << c, c, 8'(c * 20));
		run_set(3'h7, 1, 0, 8'h03);
		reset_mid_set();
		ref_check();
		conclude();
	end
	initial begin
		#720000;
		mismatches++;
		conclude();
	end
endmodule : tb_oversampling_average_filter
